// ==== agcsr_pkg.sv ====
// package for the agc channel and soft reset controller
// assumes a 40 MHz mclk; all counts derived here
package agcsr_pkg;
    localparam int unsigned CLK_HZ = 40000000;
    // agc settle time in microseconds (about 3.5 ms)
    localparam int unsigned AGC_SETTLE_US = 3500;
    localparam int unsigned AGC_SETTLE_CYC = (AGC_SETTLE_US * (CLK_HZ / 1000000));
    // soft reset initialisation: one 32 kHz cycle, 31.25 us, in nanoseconds
    localparam int unsigned SRST_INIT_NS = 31250;
    localparam int unsigned SRST_INIT_CYC = (SRST_INIT_NS * (CLK_HZ / 1000000)) / 1000;
    localparam int unsigned NCH = 3;
    localparam int unsigned GAIN_W = 4;
    localparam int unsigned AGC_W = 8;
    // field positions within the register images
    localparam int unsigned CFG0_CH_LSB = 1;
    localparam int unsigned CFG5_NEEDS_AGC_BIT = 7;
    localparam int unsigned STAT7_AGC_BIT = 5;
    localparam logic [AGC_W-1:0] AGC_RESET_VAL = 8'h80;
    localparam logic [8:0] STAT7_RESET_VAL = 9'h000;

    typedef enum logic [3:0] {
        AGCSR_ST_STANDBY = 4'h1,
        AGCSR_ST_SETTLE = 4'h2,
        AGCSR_ST_ACTIVE = 4'h4,
        AGCSR_ST_INIT = 4'h8
    } agcsr_state_t;
endpackage : agcsr_pkg

// ==== agcsr_gain_if.sv ====
// carries gain-loop signals between the top and the gain loop
// assumes both ends share mclk
`timescale 1ns/1ps
`default_nettype none
interface agcsr_gain_if;
    logic fast_mode;
    logic hold_init;
    logic preserve_on;
    logic capture;
    logic [7:0] agc_value;
    logic [7:0] slicer_value;
    logic regulating;
    modport ctrl (output fast_mode, output hold_init, output preserve_on, output capture,
        input agc_value, input slicer_value, input regulating);
    modport loop (input fast_mode, input hold_init, input preserve_on, input capture,
        output agc_value, output slicer_value, output regulating);
endinterface : agcsr_gain_if
`default_nettype wire

// ==== agcsr_gain_loop.sv ====
// digital gain loop: fast/slow tracking, envelope freeze, preserve
// assumes level inputs synchronous to mclk
`timescale 1ns/1ps
`default_nettype none
module agcsr_gain_loop #(
    parameter int unsigned SLOW_DIV = 16
) (
    // clock and reset
    input wire logic mclk,
    input wire logic sys_rst,
    input wire logic clk_en,
    // analog side
    input wire logic env_high,
    input wire logic amp_above,
    input wire logic amp_over_reg,
    // control side
    agcsr_gain_if.loop gi
);
    import agcsr_pkg::*;

    logic [7:0] agc;
    logic [7:0] held;
    logic [$clog2(SLOW_DIV)-1:0] div;
    logic [7:0] next_agc;
    logic [7:0] next_held;
    logic [$clog2(SLOW_DIV)-1:0] next_div;

    function automatic logic [7:0] step(input logic [7:0] v, input logic up);
        if (up) begin
            step = (v == 8'hFF) ? v : v + 8'h01;
        end else begin
            step = (v == 8'h00) ? v : v - 8'h01;
        end
    endfunction : step

    always_comb begin
        next_agc = agc;
        next_held = held;
        next_div = div + 1'b1;
        if (gi.hold_init) begin
            next_agc = AGC_RESET_VAL;
            next_div = '0;
        end else if (env_high) begin
            // slow mode updates only once per divider wrap
            if (gi.fast_mode || div == '0) begin
                next_agc = step(agc, amp_over_reg);
            end
        end
        if (gi.capture) begin
            next_held = agc;
        end
    end

    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            agc <= AGC_RESET_VAL;
            held <= AGC_RESET_VAL;
            div <= '0;
        end else if (clk_en) begin
            agc <= next_agc;
            held <= next_held;
            div <= next_div;
        end
    end

    assign gi.agc_value = agc;
    assign gi.slicer_value = gi.preserve_on ? held : agc;
    assign gi.regulating = amp_above && !gi.hold_init;
endmodule : agcsr_gain_loop
`default_nettype wire

// ==== agcsr_ctrl.sv ====
// top of the agc channel and soft reset controller
// assumes all inputs synchronous to mclk; commands are one-cycle pulses
// from the serial decoder
// What this block does
// - status bit 5 of register 7 set while the gain loop regulates.
// - output-needs-agc option gates data and carrier until regulating.
// - each channel gain reducible 0 dB to about -30 dB by configuration.
// - config register 0 bits 3 to 1 enable each channel.
// - disabled channel powers down path but keeps limiter powered.
// - gain loop fast during settle interval, slow afterwards.
// - gain value frozen while envelope is low.
// - preserve on/off commands; survives resets other than soft reset.
// - preserve captures settle-time gain and applies it to slicer.
// - soft reset on power-on, inactivity timeout, abort or command.
// - abort when no positive signal at end of settle interval.
// - soft reset initialises filter, agc, demodulator, oscillator; then standby.
// - soft reset keeps configuration, clears some status register 7 bits.
// - soft reset initialisation lasts one 32 kHz cycle, 31.25 us.
// - modulation transistors on during initialisation, off right after.
// - soft reset only in active mode; ignored in standby, except on power-on.
// - settle interval about 3.5 ms, output enable filter held reset.
`timescale 1ns/1ps
`default_nettype none
module agcsr_ctrl #(
    parameter int unsigned SETTLE_CYC = agcsr_pkg::AGC_SETTLE_CYC,
    parameter int unsigned NCH = agcsr_pkg::NCH,
    parameter int unsigned GAIN_W = agcsr_pkg::GAIN_W
) (
    // clock, reset, enable
    input wire logic mclk,
    input wire logic sys_rst,
    input wire logic clk_en,
    // configuration images
    input wire logic [8:0] cfg0,
    input wire logic [8:0] cfg5,
    input wire logic [NCH*GAIN_W-1:0] gain_reduce_cfg,
    // command pulses and events
    input wire logic cmd_soft_reset,
    input wire logic cmd_preserve_on,
    input wire logic cmd_preserve_off,
    input wire logic por_event,
    input wire logic inactivity_timeout,
    // analog front end
    input wire logic signal_detect,
    input wire logic env_high,
    input wire logic amp_above,
    input wire logic amp_over_reg,
    input wire logic demod_in,
    input wire logic carrier_in,
    // channel controls
    output logic [NCH-1:0] ch_path_on,
    output logic [NCH-1:0] ch_limiter_on,
    output logic [NCH*GAIN_W-1:0] ch_gain_reduce,
    output logic [NCH-1:0] mod_fet_on,
    // output path and status
    output logic demod_out,
    output logic carrier_out,
    output logic agc_regulating_flag,
    output logic oe_filter_rst,
    output logic demod_rst,
    output logic osc_rst,
    output logic abort_pulse,
    output logic [7:0] slicer_gain,
    output logic preserve_enabled,
    output logic active_mode
);
    import agcsr_pkg::*;

    // one counter times both the settle and the init interval, so it is
    // sized for the longer of the two
    localparam int unsigned CNT_MAX = (SETTLE_CYC > SRST_INIT_CYC) ? SETTLE_CYC : SRST_INIT_CYC;
    localparam int unsigned CNT_W = $clog2(CNT_MAX + 1);

    agcsr_gain_if gi ();

    agcsr_state_t state;
    agcsr_state_t next_state;
    logic [CNT_W-1:0] cnt;
    logic [CNT_W-1:0] next_cnt;
    logic preserve;
    logic next_preserve;
    logic abort_q;
    logic next_abort;
    logic reg_flag;
    logic next_reg_flag;
    logic dq;
    logic cq;
    logic next_dq;
    logic next_cq;
    logic srst_req;
    logic init_done;

    // ----------------------------------------
    // soft reset request
    // ----------------------------------------
    // power-on reaches the sequencer regardless of mode; other sources
    // need active mode
    logic settle_end;
    assign settle_end = (state == AGCSR_ST_SETTLE) && (cnt == CNT_W'(SETTLE_CYC - 1));
    assign srst_req = por_event || (((state == AGCSR_ST_ACTIVE) || (state == AGCSR_ST_SETTLE))
        && (inactivity_timeout || cmd_soft_reset));
    assign init_done = (state == AGCSR_ST_INIT) && (cnt == CNT_W'(SRST_INIT_CYC - 1));

    // ----------------------------------------
    // mode sequencer
    // ----------------------------------------
    always_comb begin
        next_state = state;
        next_cnt = cnt + 1'b1;
        next_abort = 1'b0;
        unique case (state)
            AGCSR_ST_STANDBY: begin
                next_cnt = '0;
                if (signal_detect) begin
                    next_state = AGCSR_ST_SETTLE;
                end
            end
            AGCSR_ST_SETTLE: begin
                if (settle_end) begin
                    next_cnt = '0;
                    if (!signal_detect) begin
                        next_abort = 1'b1;
                        next_state = AGCSR_ST_INIT;
                    end else begin
                        next_state = AGCSR_ST_ACTIVE;
                    end
                end
            end
            AGCSR_ST_ACTIVE: begin
                next_cnt = '0;
            end
            AGCSR_ST_INIT: begin
                if (init_done) begin
                    next_cnt = '0;
                    next_state = AGCSR_ST_STANDBY;
                end
            end
        endcase
        if (srst_req && state != AGCSR_ST_INIT) begin
            next_state = AGCSR_ST_INIT;
            next_cnt = '0;
        end
    end

    // ----------------------------------------
    // preserve flag and status
    // ----------------------------------------
    always_comb begin
        next_preserve = preserve;
        if (cmd_preserve_off || state == AGCSR_ST_INIT) begin
            next_preserve = 1'b0;
        end
        if (cmd_preserve_on) begin
            next_preserve = 1'b1;
        end
        // status bit is cleared by soft reset; configuration is not touched
        next_reg_flag = gi.regulating && (state != AGCSR_ST_INIT);
        next_dq = 1'b0;
        next_cq = 1'b0;
        if (state == AGCSR_ST_ACTIVE && |cfg0[CFG0_CH_LSB +: NCH]) begin
            if (!cfg5[CFG5_NEEDS_AGC_BIT] || reg_flag) begin
                next_dq = demod_in;
                next_cq = carrier_in;
            end
        end
    end

    // sys_rst stands for resets other than soft reset: preserve survives it
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            state <= AGCSR_ST_STANDBY;
            cnt <= '0;
            abort_q <= 1'b0;
            reg_flag <= 1'b0;
            dq <= 1'b0;
            cq <= 1'b0;
        end else if (clk_en) begin
            state <= next_state;
            cnt <= next_cnt;
            abort_q <= next_abort;
            reg_flag <= next_reg_flag;
            dq <= next_dq;
            cq <= next_cq;
        end
    end

    // preserve has no sys_rst term so it outlives ordinary resets
    always_ff @(posedge mclk) begin
        if (clk_en) begin
            preserve <= next_preserve;
        end
    end

    // ----------------------------------------
    // gain loop hookup
    // ----------------------------------------
    assign gi.fast_mode = (state == AGCSR_ST_SETTLE);
    assign gi.hold_init = (state == AGCSR_ST_INIT) || (state == AGCSR_ST_STANDBY);
    assign gi.preserve_on = preserve;
    assign gi.capture = preserve && settle_end;

    agcsr_gain_loop u_loop (
        .mclk(mclk),
        .sys_rst(sys_rst),
        .clk_en(clk_en),
        .env_high(env_high),
        .amp_above(amp_above),
        .amp_over_reg(amp_over_reg),
        .gi(gi)
    );

    // ----------------------------------------
    // outputs
    // ----------------------------------------
    assign ch_path_on = cfg0[CFG0_CH_LSB +: NCH];
    assign ch_limiter_on = '1;
    assign ch_gain_reduce = gain_reduce_cfg;
    assign mod_fet_on = {NCH{state == AGCSR_ST_INIT}};
    assign demod_out = dq;
    assign carrier_out = cq;
    assign agc_regulating_flag = reg_flag;
    assign oe_filter_rst = (state != AGCSR_ST_ACTIVE);
    assign demod_rst = (state == AGCSR_ST_INIT);
    assign osc_rst = (state == AGCSR_ST_INIT);
    assign abort_pulse = abort_q;
    assign slicer_gain = gi.slicer_value;
    assign preserve_enabled = preserve;
    assign active_mode = (state == AGCSR_ST_ACTIVE) || (state == AGCSR_ST_SETTLE);
endmodule : agcsr_ctrl
`default_nettype wire

// ==== agcsr_monitor.sv ====
// checker for the agc channel and soft reset controller ports
// assumes bind onto agcsr_ctrl; checks pause while clk_en is low
`timescale 1ns/1ps
`default_nettype none
module agcsr_monitor (
    // clock and reset
    input wire logic mclk,
    input wire logic sys_rst,
    input wire logic clk_en,
    // inputs watched
    input wire logic [8:0] cfg0,
    input wire logic [8:0] cfg5,
    input wire logic [11:0] gain_reduce_cfg,
    input wire logic cmd_soft_reset,
    input wire logic cmd_preserve_on,
    input wire logic por_event,
    input wire logic amp_above,
    // outputs watched
    input wire logic [2:0] ch_path_on,
    input wire logic [2:0] ch_limiter_on,
    input wire logic [11:0] ch_gain_reduce,
    input wire logic [2:0] mod_fet_on,
    input wire logic demod_out,
    input wire logic agc_regulating_flag,
    input wire logic oe_filter_rst,
    input wire logic demod_rst,
    input wire logic osc_rst,
    input wire logic abort_pulse,
    input wire logic preserve_enabled,
    input wire logic active_mode
);
    import agcsr_pkg::*;
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (sys_rst || !clk_en);
    // ----------------------------------------
    // init cycle counter
    // ----------------------------------------
    // counted here because the init interval is far beyond a repetition
    logic [11:0] fet_cnt;
    logic [11:0] next_fet_cnt;
    always_comb begin
        // only enabled cycles advance the design, so only they are counted
        next_fet_cnt = (mod_fet_on != 3'h0) ? fet_cnt + (clk_en ? 12'h1 : 12'h0) : 12'h0;
    end
    always_ff @(posedge mclk) begin
        fet_cnt <= sys_rst ? 12'h000 : next_fet_cnt;
    end
    limiter_kept_a: assert property (ch_limiter_on == 3'h7)
        else $error("limiter not powered");
    path_enable_a: assert property (ch_path_on == cfg0[3:1])
        else $error("channel enable mismatch");
    gain_pass_a: assert property (ch_gain_reduce == gain_reduce_cfg)
        else $error("gain reduction mismatch");
    init_length_a: assert property ($fell(mod_fet_on[0]) && !$past(sys_rst)
        |-> fet_cnt == SRST_INIT_CYC) else $error("init length wrong");
    soft_enter_a: assert property (cmd_soft_reset && active_mode && !oe_filter_rst
        |=> mod_fet_on == 3'h7 && !active_mode) else $error("soft reset not taken");
    standby_ignore_a: assert property (cmd_soft_reset && !active_mode
        && mod_fet_on == 3'h0 && !por_event |=> mod_fet_on == 3'h0)
        else $error("soft reset taken in standby");
    gate_agc_a: assert property (cfg5[7] && !agc_regulating_flag && !amp_above
        |=> !demod_out) else $error("data passed before regulation");
    flag_cause_a: assert property ($rose(agc_regulating_flag) |-> $past(amp_above))
        else $error("flag set without regulation");
    abort_pulse_a: assert property (abort_pulse |-> mod_fet_on == 3'h7 ##1 !abort_pulse)
        else $error("abort pulse wrong");
    init_resets_a: assert property (mod_fet_on == 3'h7
        |-> demod_rst && osc_rst && oe_filter_rst) else $error("init resets missing");
    preserve_clear_a: assert property (mod_fet_on == 3'h7 && !cmd_preserve_on
        |=> !preserve_enabled) else $error("preserve not cleared");
    preserve_set_a: assert property (cmd_preserve_on |=> preserve_enabled)
        else $error("preserve not set");
    cover property (abort_pulse);
    cover property ($rose(mod_fet_on[0]));
    cover property (cmd_preserve_on ##1 preserve_enabled);
endmodule : agcsr_monitor
bind agcsr_ctrl agcsr_monitor agcsr_monitor_inst (.mclk(mclk), .sys_rst(sys_rst),
    .clk_en(clk_en), .cfg0(cfg0), .cfg5(cfg5), .gain_reduce_cfg(gain_reduce_cfg),
    .cmd_soft_reset(cmd_soft_reset), .cmd_preserve_on(cmd_preserve_on),
    .por_event(por_event), .amp_above(amp_above), .ch_path_on(ch_path_on),
    .ch_limiter_on(ch_limiter_on), .ch_gain_reduce(ch_gain_reduce),
    .mod_fet_on(mod_fet_on), .demod_out(demod_out),
    .agc_regulating_flag(agc_regulating_flag), .oe_filter_rst(oe_filter_rst),
    .demod_rst(demod_rst), .osc_rst(osc_rst), .abort_pulse(abort_pulse),
    .preserve_enabled(preserve_enabled), .active_mode(active_mode));
`default_nettype wire

// ==== agcsr_mcu.sv ====
// command source standing in for the microcontroller
// assumes the bench raises go for one cycle per command
`timescale 1ns/1ps
`default_nettype none
module agcsr_mcu (
    // command request
    input wire logic mclk,
    input wire logic go,
    input wire logic [1:0] op,
    // command pulses
    output logic cmd_soft_reset,
    output logic cmd_preserve_on,
    output logic cmd_preserve_off
);
    always_ff @(posedge mclk) begin
        cmd_soft_reset <= go && op == 2'h0;
        cmd_preserve_on <= go && op == 2'h1;
        cmd_preserve_off <= go && op == 2'h2;
    end
endmodule : agcsr_mcu
`default_nettype wire

// ==== tb.sv ====
// self-checking bench for the agc channel and soft reset controller
// assumes package, design, checker and command model compiled first
`timescale 1ns/1ps
`default_nettype none
module tb;
    import agcsr_pkg::*;
    typedef struct {int id; logic [11:0] exp;} agcsr_note_t;
    agcsr_note_t notes[$];
    string nm [12] = '{"fet", "path", "lim", "gred", "dout", "cout", "flag", "act", "oer",
        "pres", "abort", "sgain"};
    int err_total = 0;
    int cmp_count = 0;
    int tick = 0;
    int ab_seen = 0;
    int seed = 32'hBE4B;
    logic mclk = 1'b0;
    logic sys_rst = 1'b1;
    logic go = 1'b0;
    logic [1:0] op = 2'h0;
    logic [8:0] cfg0 = 9'h000;
    logic [8:0] cfg5 = 9'h080;
    logic [11:0] gcfg = 12'h000;
    logic por = 1'b0;
    logic sd = 1'b0;
    logic amp = 1'b0;
    logic ovr = 1'b0;
    logic din = 1'b0;
    logic cin = 1'b0;
    logic env = 1'b1;
    logic ina = 1'b0;
    logic ce = 1'b1;
    logic c_sr, c_on, c_off, dout, cout, flag, ab, pres, act, oer;
    logic [2:0] path, lim, fet;
    logic [11:0] gred;
    logic [7:0] sg;
    // ----------------------------------------
    // instances, clock, checking
    // ----------------------------------------
    agcsr_mcu agcsr_mcu_inst (.mclk(mclk), .go(go), .op(op), .cmd_soft_reset(c_sr),
        .cmd_preserve_on(c_on), .cmd_preserve_off(c_off));
    agcsr_ctrl #(.SETTLE_CYC(20)) agcsr_ctrl_inst (.mclk(mclk), .sys_rst(sys_rst),
        .clk_en(ce), .cfg0(cfg0), .cfg5(cfg5), .gain_reduce_cfg(gcfg),
        .cmd_soft_reset(c_sr), .cmd_preserve_on(c_on), .cmd_preserve_off(c_off),
        .por_event(por), .inactivity_timeout(ina), .signal_detect(sd), .env_high(env),
        .amp_above(amp), .amp_over_reg(ovr), .demod_in(din), .carrier_in(cin),
        .ch_path_on(path), .ch_limiter_on(lim), .ch_gain_reduce(gred), .mod_fet_on(fet),
        .demod_out(dout), .carrier_out(cout), .agc_regulating_flag(flag),
        .oe_filter_rst(oer), .demod_rst(), .osc_rst(), .abort_pulse(ab),
        .slicer_gain(sg), .preserve_enabled(pres), .active_mode(act));
    initial begin
        forever #12.5 mclk = ~mclk;
    end
    function automatic logic [11:0] got(input int id);
        case (id)
            0: return {9'h000, fet};
            1: return {9'h000, path};
            2: return {9'h000, lim};
            3: return gred;
            4: return {11'h000, dout};
            5: return {11'h000, cout};
            6: return {11'h000, flag};
            7: return {11'h000, act};
            8: return {11'h000, oer};
            9: return {11'h000, pres};
            11: return {4'h0, sg};
            default: return 12'(ab_seen);
        endcase
    endfunction : got
    // the watcher compares at the falling edge, when outputs have settled
    always @(negedge mclk) begin
        agcsr_note_t n;
        logic [11:0] v;
        while (notes.size() > 0) begin
            n = notes.pop_front();
            v = got(n.id);
            cmp_count++;
            if (v !== n.exp) begin
                err_total++;
                $display("MISMATCH %s exp %h got %h", nm[n.id], n.exp, v);
            end
        end
    end
    always @(posedge mclk) begin
        tick++;
        if (ab === 1'b1) ab_seen++;
        if (tick == 8000) begin
            err_total++;
            test_done;
        end
    end
    task automatic chk(input int id, input logic [11:0] e);
        notes.push_back('{id, e});
    endtask : chk
    task automatic cyc(input int n);
        repeat (n) @(posedge mclk);
    endtask : cyc
    task automatic send(input logic [1:0] c);
        op <= c;
        go <= 1'b1;
        @(posedge mclk);
        go <= 1'b0;
    endtask : send
    task automatic test_done;
        repeat (2) @(negedge mclk);
        $display("checks %0d mismatches %0d", cmp_count, err_total);
        if (err_total == 0 && cmp_count > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : test_done
    initial begin
        cyc(12);
        sys_rst <= 1'b0;
        send(2'h2);
        cfg0 <= 9'($random(seed));
        gcfg <= 12'($random(seed));
        ovr <= 1'($random(seed));
        cyc(2);
        chk(1, {9'h000, cfg0[3:1]});
        chk(2, 12'h007);
        chk(3, gcfg);
        $display("test channels done");
        sd <= 1'b1;
        din <= 1'b1;
        cin <= 1'b1;
        cfg0[1] <= 1'b1;
        cyc(2);
        chk(7, 12'h001);
        chk(8, 12'h001);
        cyc(25);
        chk(8, 12'h000);
        chk(4, 12'h000);
        chk(5, 12'h000);
        amp <= 1'b1;
        cyc(3);
        chk(6, 12'h001);
        chk(4, 12'h001);
        chk(5, 12'h001);
        cfg5 <= 9'h000;
        amp <= 1'b0;
        cyc(3);
        chk(4, 12'h001);
        send(2'h1);
        cyc(2);
        chk(9, 12'h001);
        $display("test settle and gating done");
        send(2'h0);
        sd <= 1'b0;
        cyc(3);
        chk(0, 12'h007);
        chk(7, 12'h000);
        chk(9, 12'h000);
        cyc(1247);
        chk(0, 12'h007);
        cyc(1);
        chk(0, 12'h000);
        chk(8, 12'h001);
        send(2'h0);
        cyc(3);
        chk(0, 12'h000);
        $display("test soft reset done");
        send(2'h1);
        cyc(2);
        sys_rst <= 1'b1;
        cyc(1);
        sys_rst <= 1'b0;
        cyc(2);
        chk(9, 12'h001);
        sd <= 1'b1;
        cyc(3);
        sd <= 1'b0;
        cyc(25);
        chk(10, 12'h001);
        chk(0, 12'h007);
        chk(9, 12'h000);
        chk(11, {4'h0, AGC_RESET_VAL});
        cyc(1250);
        por <= 1'b1;
        cyc(1);
        por <= 1'b0;
        cyc(2);
        chk(0, 12'h007);
        $display("test abort and power-on done");
        cyc(1250);
        send(2'h1);
        ovr <= 1'b1;
        sd <= 1'b1;
        cyc(23);
        // nineteen fast steps up from the reset value are captured at settle end
        chk(11, {4'h0, AGC_RESET_VAL + 8'h13});
        cyc(40);
        chk(11, {4'h0, AGC_RESET_VAL + 8'h13});
        send(2'h2);
        env <= 1'b0;
        cyc(3);
        // twenty fast steps plus two slow steps, one per 16-cycle wrap
        chk(11, {4'h0, AGC_RESET_VAL + 8'h16});
        cyc(20);
        chk(11, {4'h0, AGC_RESET_VAL + 8'h16});
        $display("test gain loop done");
        ina <= 1'b1;
        cyc(1);
        ina <= 1'b0;
        cyc(2);
        chk(0, 12'h007);
        chk(11, {4'h0, AGC_RESET_VAL});
        // ten frozen cycles stretch the init interval by ten
        ce <= 1'b0;
        cyc(10);
        ce <= 1'b1;
        cyc(1245);
        chk(0, 12'h007);
        cyc(3);
        chk(0, 12'h000);
        $display("test timeout and clock enable done");
        test_done;
    end
endmodule : tb
`default_nettype wire
